// ---- seq_pkg.sv ----
// Shared constants for the low-power sequencer control block.
// Assumes one synchronous clock domain shared by both ends.
package seq_pkg;
  localparam int SLOT_COUNT = 32;
  localparam int PTR_W = 5;
  localparam int TRIG_W = 5;
  localparam int INSTR_W = 16;
  // Instruction field positions
  localparam int CODE_MSB = 15;
  localparam int CODE_LSB = 12;
  localparam int EXTRA_MSB = 3;
  localparam int EXTRA_LSB = 0;
  localparam int OPND_MSB = 11;
  localparam int OPND_LSB = 4;
  localparam int DISP_MSB = 8;
  localparam int DISP_LSB = 4;
  localparam logic [3:0] CODE_TERM = 4'hf;
  localparam logic [3:0] CODE_BRANCH = 4'h8;
  localparam logic [3:0] CODE_MASK_CLR = 4'he;
  localparam logic [7:0] OPERANDS_ZERO = 8'h00;
  localparam logic [3:0] EXTRA_TERM = 4'h0;
  // Control register layout
  localparam int CTRL_W = 8;
  localparam int CTRL_TRIG_LSB = 0;
  localparam int CTRL_RUN_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [4:0] PTR_LAST = 5'h1f;
endpackage

// ---- seq_if.sv ----
// Interface between the sequencer and the CPU side.
// Assumes both modules share clk and reset.
`timescale 1ns/1ps
interface seq_if (
  input wire logic clk,
  input wire logic reset
);
  logic [7:0] ctrl_wdata;
  logic ctrl_we;
  logic force_stop;
  logic [7:0] seq_control_reg;
  logic [4:0] instr_pointer;
  logic seq_busy;
  logic seq_stopped;
  logic mask_clr_req;
  logic mask_set;
  logic flag_set;
  logic seq_event_mask;
  logic seq_event_request_flag;
  logic seq_end_interrupt;
  modport device (
    input clk, reset, ctrl_wdata, ctrl_we, force_stop, seq_event_mask,
    output seq_control_reg, instr_pointer, seq_busy, seq_stopped,
    output mask_clr_req
  );
  modport cpu (
    input clk, reset, seq_control_reg, instr_pointer, seq_busy,
    input seq_stopped, mask_clr_req,
    output ctrl_wdata, ctrl_we, force_stop, mask_set, flag_set,
    output seq_event_mask, seq_event_request_flag, seq_end_interrupt
  );
endinterface

// ---- seq_slot_mem.sv ----
// Instruction slot storage, written only while the sequencer is stopped.
// Assumes the caller gates writes with the stopped state.
`timescale 1ns/1ps
module seq_slot_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter int DW = 16
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  // Slots are not reset: a forced stop must leave them intact
  logic [DW-1:0] slot_mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      slot_mem[waddr] <= wdata;
    end
  end

  assign rdata = slot_mem[raddr];
endmodule

// ---- seq_device.sv ----
// Sequencer control end: trigger wait, slot stepping, termination, stop.
// Assumes the CPU end owns the mask/flag bits and slot writes obey stop.
// Branches are always taken: condition flags sit outside this block.
// Contract
// (R1) Mask bit gates end interrupt generation
// (R2) CPU sets mask and flag before run
// (R3) Sequencer mask clear raises end interrupt
// (R4) With interrupts off, mask zero means done
// (R5) CPU never clears mask/flag while running
// (R6) Software keeps handler and sequencer apart
// (R7) Selected trigger starts a round
// (R8) Slot zero first, then pointer slot
// (R9) Termination returns to trigger wait
// (R10) Force stop aborts into stopped state
// (R11) Force stop resets control, keeps slots
// (R12) Termination code clears pointer and ends the round
// (R13) Last slot auto-terminates unless term/branch
// (R14) Slots written only while stopped
`timescale 1ns/1ps
module seq_device #(
  parameter int TRIG_COUNT = 32
) (
  // Link to CPU end
  seq_if.device lnk,
  // Trigger sources
  input wire logic [TRIG_COUNT-1:0] trigger_in,
  // Slot programming
  input wire logic slot_we,
  input wire logic [seq_pkg::PTR_W-1:0] slot_waddr,
  input wire logic [seq_pkg::INSTR_W-1:0] slot_wdata,
  // Observation
  output logic [seq_pkg::INSTR_W-1:0] cur_instr,
  output logic instr_strobe
);
  // Stopped: control setup and slot writes are allowed
  // Wait: armed, looking for the selected trigger
  // Run: one slot executes per clock
  typedef enum logic [2:0] {
    ST_STOPPED = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } seq_state_e;

  seq_state_e state_ff;
  seq_state_e nxt_state;
  logic [7:0] ctrl_ff;
  logic [seq_pkg::PTR_W-1:0] ptr_ff;
  logic [seq_pkg::PTR_W-1:0] nxt_ptr;
  // Slot read is combinational, so the slot at ptr_ff runs this cycle
  logic [seq_pkg::INSTR_W-1:0] instr;
  logic [seq_pkg::INSTR_W-1:0] instr_ff;
  logic strobe_ff;
  logic mask_clr_ff;
  logic run_bit;
  logic trig_hit;
  logic is_term;
  logic is_branch;
  logic is_mask_clr;
  logic end_round;
  logic in_run;
  logic [4:0] trig_sel;

  function automatic logic [3:0] op_code(input logic [15:0] w);
    op_code = w[seq_pkg::CODE_MSB:seq_pkg::CODE_LSB];
  endfunction

  // Only the exact encoding ends a round before slot 31; other 0xf words do not
  function automatic logic term_word(input logic [15:0] w);
    term_word = op_code(w) == seq_pkg::CODE_TERM
      && w[seq_pkg::OPND_MSB:seq_pkg::OPND_LSB] == seq_pkg::OPERANDS_ZERO
      && w[seq_pkg::EXTRA_MSB:seq_pkg::EXTRA_LSB] == seq_pkg::EXTRA_TERM;
  endfunction

  // Displacement wraps inside the 32 slots
  function automatic logic [4:0] branch_target(input logic [4:0] p,
    input logic [15:0] w);
    branch_target = p + w[seq_pkg::DISP_MSB:seq_pkg::DISP_LSB];
  endfunction

  assign run_bit = ctrl_ff[seq_pkg::CTRL_RUN_BIT];
  assign in_run = state_ff == ST_RUN;
  assign trig_sel = ctrl_ff[seq_pkg::CTRL_TRIG_LSB +: seq_pkg::TRIG_W];
  assign trig_hit = trigger_in[trig_sel]; // [R7]

  seq_slot_mem #(
    .DEPTH(seq_pkg::SLOT_COUNT),
    .AW(seq_pkg::PTR_W),
    .DW(seq_pkg::INSTR_W)
  ) u_slots (
    // Writes outside the stopped state are dropped, not queued
    .clk(lnk.clk),
    .we(slot_we && state_ff == ST_STOPPED), // [R14]
    .waddr(slot_waddr),
    .wdata(slot_wdata),
    .raddr(ptr_ff),
    .rdata(instr)
  );

  // Termination needs exact operand and extra-nibble encoding
  assign is_term = term_word(instr); // [R12]
  assign is_branch = op_code(instr) == seq_pkg::CODE_BRANCH;
  assign is_mask_clr = op_code(instr) == seq_pkg::CODE_MASK_CLR;
  // Falling off the last slot terminates unless it steers elsewhere
  assign end_round = is_term
    || (ptr_ff == seq_pkg::PTR_LAST && !is_branch); // [R13]

  always_comb begin
    nxt_state = state_ff;
    nxt_ptr = ptr_ff;
    case (state_ff)
      ST_STOPPED: begin
        // Setting the run bit arms the trigger
        if (run_bit) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // The selected trigger only counts while armed
        if (trig_hit) begin
          nxt_state = ST_RUN; // [R7]
          nxt_ptr = seq_pkg::PTR_RESET; // [R8]
        end
      end
      ST_RUN: begin
        if (end_round) begin
          nxt_state = ST_WAIT; // [R9]
          nxt_ptr = seq_pkg::PTR_RESET; // [R12]
        end else if (is_branch) begin
          nxt_ptr = branch_target(ptr_ff, instr);
        end else begin
          nxt_ptr = ptr_ff + 5'h01; // [R8]
        end
      end
      default: begin
        nxt_state = ST_STOPPED;
      end
    endcase
    // A cleared run bit parks the device but never cuts a round short
    if (!run_bit && !in_run) begin
      nxt_state = ST_STOPPED;
    end
    // Forced stop beats trigger, termination and the run bit
    if (lnk.force_stop) begin
      nxt_state = ST_STOPPED; // [R10]
      nxt_ptr = seq_pkg::PTR_RESET;
    end
  end

  always_ff @(posedge lnk.clk) begin
    if (lnk.reset) begin
      state_ff <= ST_STOPPED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pointer returns to slot zero on every stop and every round end
  always_ff @(posedge lnk.clk) begin
    if (lnk.reset) begin
      ptr_ff <= seq_pkg::PTR_RESET;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // Control register; forced stop wins over a same-cycle write
  always_ff @(posedge lnk.clk) begin
    if (lnk.reset) begin
      ctrl_ff <= seq_pkg::CTRL_RESET;
    end else if (lnk.force_stop) begin
      ctrl_ff <= seq_pkg::CTRL_RESET; // [R11]
    end else if (lnk.ctrl_we) begin
      ctrl_ff <= lnk.ctrl_wdata;
    end
  end

  // Sequencer-side request to clear the event mask
  always_ff @(posedge lnk.clk) begin
    if (lnk.reset) begin
      mask_clr_ff <= 1'b0;
    end else begin
      mask_clr_ff <= in_run && is_mask_clr
        && !lnk.force_stop; // [R3]
    end
  end

  always_ff @(posedge lnk.clk) begin
    if (lnk.reset) begin
      instr_ff <= '0;
    end else begin
      instr_ff <= instr;
    end
  end

  // Strobe says cur_instr holds the slot executed in the cycle before
  always_ff @(posedge lnk.clk) begin
    if (lnk.reset) begin
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= in_run;
    end
  end

  assign lnk.seq_control_reg = ctrl_ff;
  assign lnk.instr_pointer = ptr_ff;
  assign lnk.seq_busy = in_run;
  assign lnk.seq_stopped = state_ff == ST_STOPPED;
  assign lnk.mask_clr_req = mask_clr_ff;
  assign cur_instr = instr_ff;
  assign instr_strobe = strobe_ff;
endmodule

// ---- seq_cpu_end.sv ----
// CPU end: event mask and request flag bits and the end interrupt.
// Assumes software sets both bits before starting the sequencer.
`timescale 1ns/1ps
module seq_cpu_end (
  // Link to sequencer
  seq_if.cpu lnk,
  // Software access to mask and flag
  input wire logic sw_mask_we,
  input wire logic sw_mask_wdata,
  input wire logic sw_flag_we,
  input wire logic sw_flag_wdata,
  // Software access to the control register
  input wire logic sw_ctrl_we,
  input wire logic [7:0] sw_ctrl_wdata,
  input wire logic sw_force_stop,
  // Global interrupt disable
  input wire logic global_interrupt_disable,
  // Status to software
  output logic run_finished,
  output logic cpu_irq
);
  logic mask_ff;
  logic flag_ff;
  logic running;
  logic clr_blocked;

  assign running = lnk.seq_control_reg[seq_pkg::CTRL_RUN_BIT];
  // Clearing mask or flag while running is refused
  assign clr_blocked = running; // [R5]

  always_ff @(posedge lnk.clk) begin
    if (lnk.reset) begin
      mask_ff <= 1'b1;
    end else if (lnk.mask_clr_req) begin
      mask_ff <= 1'b0; // [R3]
    end else if (sw_mask_we && (sw_mask_wdata || !clr_blocked)) begin
      mask_ff <= sw_mask_wdata; // [R2] [R5]
    end
  end

  always_ff @(posedge lnk.clk) begin
    if (lnk.reset) begin
      flag_ff <= 1'b0;
    end else if (lnk.mask_clr_req) begin
      flag_ff <= 1'b1; // [R3]
    end else if (sw_flag_we && (sw_flag_wdata || !clr_blocked)) begin
      flag_ff <= sw_flag_wdata; // [R2] [R5]
    end
  end

  assign lnk.ctrl_we = sw_ctrl_we;
  assign lnk.ctrl_wdata = sw_ctrl_wdata;
  assign lnk.force_stop = sw_force_stop;
  assign lnk.mask_set = sw_mask_we && sw_mask_wdata;
  assign lnk.flag_set = sw_flag_we && sw_flag_wdata;
  assign lnk.seq_event_mask = mask_ff;
  assign lnk.seq_event_request_flag = flag_ff;
  // Flag at 1 with mask at 0 is the end interrupt
  assign lnk.seq_end_interrupt = flag_ff && !mask_ff; // [R1] [R3]
  assign cpu_irq = lnk.seq_end_interrupt && !global_interrupt_disable;
  assign run_finished = global_interrupt_disable && !mask_ff; // [R4]
endmodule

// ---- seq_link_checker.sv ----
// Assertions on the link between sequencer and CPU end.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module seq_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link signals
  input wire logic force_stop,
  input wire logic [7:0] seq_control_reg,
  input wire logic [4:0] instr_pointer,
  input wire logic seq_busy,
  input wire logic seq_stopped,
  input wire logic mask_clr_req,
  input wire logic mask_set,
  input wire logic flag_set,
  input wire logic seq_event_mask,
  input wire logic seq_event_request_flag,
  input wire logic seq_end_interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_irq;
    !seq_event_mask && seq_event_request_flag && seq_end_interrupt;
  endsequence
  property p_gate;
    seq_end_interrupt == (seq_event_request_flag && !seq_event_mask);
  endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_clr;
    mask_clr_req |=> s_irq;
  endproperty
  a_clr: assert property (p_clr) else $error("mask clear");
  property p_src;
    mask_clr_req |-> $past(seq_busy);
  endproperty
  a_src: assert property (p_src) else $error("clear source");
  property p_run;
    $rose(seq_busy) |-> $past(seq_control_reg[7]);
  endproperty
  a_run: assert property (p_run) else $error("start");
  property p_start;
    $rose(seq_busy) |-> instr_pointer == 5'h00;
  endproperty
  a_start: assert property (p_start) else $error("slot zero");
  property p_term;
    $fell(seq_busy) && !$past(force_stop) |-> !seq_stopped &&
      instr_pointer == 5'h00;
  endproperty
  a_term: assert property (p_term) else $error("end");
  property p_stop;
    force_stop |=> seq_stopped && !seq_busy && seq_control_reg == 8'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_idle;
    seq_stopped |-> instr_pointer == 5'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_park;
    seq_stopped && !seq_control_reg[7] |=> seq_stopped;
  endproperty
  a_park: assert property (p_park) else $error("park");
  property p_mset;
    mask_set && !mask_clr_req |=> seq_event_mask;
  endproperty
  a_mset: assert property (p_mset) else $error("mask set");
  property p_fset;
    flag_set |=> seq_event_request_flag;
  endproperty
  a_fset: assert property (p_fset) else $error("flag set");
endmodule

// ---- low_power_sequencer_control_bench.sv ----
// Bench joining sequencer and CPU end through the link interface.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
module low_power_sequencer_control_bench;
  typedef struct packed {
    logic [4:0] sel;
    logic [4:0] last;
    logic clr;
    logic gid;
  } row_s;
  // With clr, last 0 would put the mask clear over the termination code in slot 0, so last >= 1
  row_s rows[4] = '{'{5'h00, 5'h01, 1'h1, 1'h0}, '{5'h1f, 5'h03, 1'h0, 1'h1},
    '{5'h0a, 5'h1f, 1'h1, 1'h1}, '{5'h15, 5'h02, 1'h0, 1'h0}};
  logic clk = 0, reset = 1, gid = 0, sw_force_stop = 0, cpu_irq;
  logic slot_we = 0, sw_mask_we = 0, sw_mask_wdata = 0;
  logic sw_flag_we = 0, sw_flag_wdata = 0, sw_ctrl_we = 0;
  logic [7:0] sw_ctrl_wdata = '0;
  logic [4:0] slot_waddr = '0;
  logic [15:0] slot_wdata = '0;
  logic [31:0] trig = '0;
  logic strobe, run_fin;
  logic [15:0] cur;
  int n_fail = 0, checks = 0;
  always #2 clk = ~clk;
  seq_if lnk (.clk(clk), .reset(reset));
  seq_device #(.TRIG_COUNT(32)) i_seq_device (.lnk(lnk), .trigger_in(trig),
    .slot_we(slot_we), .slot_waddr(slot_waddr), .slot_wdata(slot_wdata),
    .cur_instr(cur), .instr_strobe(strobe));
  seq_cpu_end i_seq_cpu_end (.lnk(lnk), .sw_mask_we(sw_mask_we),
    .sw_mask_wdata(sw_mask_wdata), .sw_flag_we(sw_flag_we),
    .sw_flag_wdata(sw_flag_wdata), .sw_ctrl_we(sw_ctrl_we),
    .sw_ctrl_wdata(sw_ctrl_wdata), .sw_force_stop(sw_force_stop),
    .global_interrupt_disable(gid), .run_finished(run_fin),
    .cpu_irq(cpu_irq));
  seq_link_checker i_seq_link_checker (.clk(clk), .reset(reset),
    .force_stop(lnk.force_stop), .seq_control_reg(lnk.seq_control_reg),
    .instr_pointer(lnk.instr_pointer), .seq_busy(lnk.seq_busy),
    .seq_stopped(lnk.seq_stopped), .mask_clr_req(lnk.mask_clr_req),
    .mask_set(lnk.mask_set), .flag_set(lnk.flag_set),
    .seq_event_mask(lnk.seq_event_mask),
    .seq_event_request_flag(lnk.seq_event_request_flag),
    .seq_end_interrupt(lnk.seq_end_interrupt));
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic ok, string msg);
    checks++;
    if (ok !== 1'h1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic wctl(logic [7:0] v);
    sw_ctrl_wdata = v;
    sw_ctrl_we = 1;
    tick();
    sw_ctrl_we = 0;
    tick(2);
  endtask
  // Slot image: mask clear in slot 0 if asked, termination code in slot k unless k is 31
  function automatic logic [15:0] slot_val(logic [4:0] i, k, logic clr);
    return (i == 5'h00 && clr) ? 16'he000 :
      (i == k && k != 5'h1f) ? 16'hf000 : 16'h1234;
  endfunction
  // Slots are only accepted while stopped, so callers stop first
  task automatic load(logic [4:0] k, logic clr);
    slot_we = 1;
    for (int i = 0; i < 32; i++) begin
      slot_waddr = 5'(i);
      slot_wdata = slot_val(5'(i), k, clr);
      tick();
    end
    slot_we = 0;
  endtask
  task automatic run(row_s r);
    int n;
    logic [15:0] want;
    sw_mask_wdata = 1;
    sw_flag_wdata = 1;
    sw_mask_we = 1;
    sw_flag_we = 1;
    gid = r.gid;
    tick();
    sw_mask_we = 0;
    sw_flag_we = 0;
    wctl({3'h4, r.sel});
    trig = ~(32'h1 << r.sel);
    tick(3);
    chk(lnk.seq_busy === 1'h0, "wrong trigger");
    trig = 32'h1 << r.sel;
    tick();
    trig = '0;
    n = 0;
    // Nothing shared is touched while the round runs
    while (lnk.seq_busy === 1'h1 && n < 40) begin
      chk(lnk.instr_pointer === 5'(n), "slot order");
      want = slot_val(5'(n - 1), r.last, r.clr);
      chk(strobe === (n > 0) && (n == 0 || cur === want), "instr");
      n++;
      tick();
    end
    chk(n == r.last + 1, "round length");
    want = slot_val(r.last, r.last, r.clr);
    chk(strobe === 1'h1 && cur === want, "last slot");
    chk(run_fin === (r.clr && r.gid), "finished");
    chk(lnk.instr_pointer === 5'h0 && !lnk.seq_stopped, "end");
    chk(lnk.seq_event_mask === !r.clr, "mask");
    chk(cpu_irq === (r.clr && !r.gid), "irq");
    $display("run sel %0d done", r.sel);
  endtask
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(6);
    reset = 0;
    chk(lnk.seq_event_mask && lnk.seq_stopped && !lnk.seq_busy, "rst");
    foreach (rows[i]) begin
      wctl(8'h00);
      load(rows[i].last, rows[i].clr);
      run(rows[i]);
    end
    sw_mask_wdata = 0;
    sw_mask_we = 1;
    tick();
    sw_mask_we = 0;
    tick();
    chk(lnk.seq_event_mask === 1'h1, "mask write");
    wctl(8'h00);
    load(5'h08, 1'h0);
    wctl(8'h80);
    trig = 32'h1;
    tick();
    trig = '0;
    tick(5);
    sw_force_stop = 1;
    tick();
    sw_force_stop = 0;
    chk(lnk.seq_stopped && lnk.seq_control_reg === 8'h0, "stop");
    $display("force stop done");
    // Slots must survive the stop, so no reload here
    run('{5'h03, 5'h08, 1'h0, 1'h0});
    wrap_up();
  end
  initial begin
    #20000;
    n_fail++;
    $display("MISMATCH %0t watchdog", $time);
    wrap_up();
  end
endmodule
